// ### rtl/bst_map.svh
// Purpose: Constants for the boundary-scan test port
// Assumes: Test clock is sampled by the core clock
// Notes: Instruction codes are three bits wide
`ifndef BST_MAP_SVH
`define BST_MAP_SVH
`define BST_IR_W 3
`define BST_IR_EXTEST 3'h0
`define BST_IR_IDCODE 3'h1
`define BST_IR_SAMPLEZ 3'h2
`define BST_IR_SAMPLE 3'h4
`define BST_BSR_W 8
`define BST_ID_W 32
`define BST_ID_VALUE 32'h0000a5a5 // Arbitrary value, names no maker
`endif

// ### rtl/bst_pkg.sv
// Purpose: Types for the boundary-scan test port
// Assumes: None
// Notes: Sixteen controller states
package bst_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bst_state_t;
endpackage

// ### rtl/bst_tap.sv
// Purpose: Boundary-scan test access port, sampled test clock
// Assumes: Test clock well below half the core clock rate
// Notes: Boundary register models a small ring of I/O pins
// Summary of operation
// - Controller state advances only on test clock edges
// - Mode select sampled on each rising test clock edge
// - Serial data in sampled on rising test clock edge
// - Serial data out updated on falling test clock edge
// - One instruction register, several data registers selected by instruction
// - Only external test and sample-floated take over the memory pins
// - Three-bit codes: 000 extest, 001 id, 010 sample-z, 100 sample
// - Id code loaded at reset, test-logic-reset, capture-IR; applied on update-IR
// - Five ones on mode select reach test-logic-reset; reset also does
// - Data in sampled and output enabled only in shift states
`timescale 1ns/100ps
`default_nettype none
`include "bst_map.svh"
module bst_tap (
  input wire logic core_clk_i,                       // Core clock
  input wire logic sys_rst_i,                        // Async reset, high
  input wire logic tck_i,                            // Test clock pin
  input wire logic tms_i,                            // Mode select pin
  input wire logic tdi_i,                            // Serial data in pin
  input wire logic [`BST_BSR_W-1:0] pins_in_i,       // Pin levels to capture
  output logic tdo_o,                                // Serial data out
  output logic tdo_oe_o,                             // Serial out drive enable
  output logic [`BST_BSR_W-1:0] pins_out_o,          // Boundary drive values
  output logic test_own_o,                           // Pins taken by test
  output logic outs_float_o,                         // Data outputs floated
  output bst_pkg::bst_state_t state_o                // Controller state
);
  import bst_pkg::*;
  logic [2:0] tck_s, tms_s, tdi_s;
  logic [`BST_BSR_W-1:0] pins_s1, pins_s2;
  logic rise, fall;
  bst_state_t state, next_state;
  logic [`BST_IR_W-1:0] ir_sh, ir, next_ir_sh, next_ir;
  logic [`BST_ID_W-1:0] dr_sh, next_dr_sh;
  logic [`BST_BSR_W-1:0] bsr_upd, next_bsr_upd;
  logic byp, next_byp;
  logic tdo, next_tdo, oe, next_oe;
  logic own, next_own, flt, next_flt;
  // Two-flop synchronisers, stage 2 and a delay stage feed edge detect
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tck_s <= 3'h0;
      tms_s <= 3'h7;
      tdi_s <= 3'h7;
      pins_s1 <= '0;
      pins_s2 <= '0;
    end else begin
      tck_s <= {tck_s[1:0], tck_i};
      tms_s <= {tms_s[1:0], tms_i};
      tdi_s <= {tdi_s[1:0], tdi_i};
      pins_s1 <= pins_in_i;
      pins_s2 <= pins_s1;
    end
  end
  assign rise = tck_s[1] & ~tck_s[2];
  assign fall = ~tck_s[1] & tck_s[2];
  wire logic tms = tms_s[1];
  wire logic tdi = tdi_s[1];
  always_comb begin
    next_state = state;
    if (rise) begin
      case (state)
        TLR: next_state = tms ? TLR : RTI;
        RTI: next_state = tms ? SEL_DR : RTI;
        SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
        CAP_DR: next_state = tms ? EX1_DR : SH_DR;
        SH_DR: next_state = tms ? EX1_DR : SH_DR;
        EX1_DR: next_state = tms ? UPD_DR : PAU_DR;
        PAU_DR: next_state = tms ? EX2_DR : PAU_DR;
        EX2_DR: next_state = tms ? UPD_DR : SH_DR;
        UPD_DR: next_state = tms ? SEL_DR : RTI;
        SEL_IR: next_state = tms ? TLR : CAP_IR;
        CAP_IR: next_state = tms ? EX1_IR : SH_IR;
        SH_IR: next_state = tms ? EX1_IR : SH_IR;
        EX1_IR: next_state = tms ? UPD_IR : PAU_IR;
        PAU_IR: next_state = tms ? EX2_IR : PAU_IR;
        EX2_IR: next_state = tms ? UPD_IR : SH_IR;
        UPD_IR: next_state = tms ? SEL_DR : RTI;
        default: next_state = TLR;
      endcase
    end
  end
  always_comb begin
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_dr_sh = dr_sh;
    next_bsr_upd = bsr_upd;
    next_byp = byp;
    if (rise) begin
      // Id code takes effect on entry, not one test clock later
      if (next_state == TLR) begin
        next_ir = `BST_IR_IDCODE;
        next_ir_sh = `BST_IR_IDCODE;
      end
      case (state)
        CAP_IR: next_ir_sh = `BST_IR_IDCODE;
        SH_IR: next_ir_sh = {tdi, ir_sh[`BST_IR_W-1:1]};
        UPD_IR: next_ir = ir_sh;
        CAP_DR: begin
          next_byp = 1'b0;
          case (ir)
            `BST_IR_IDCODE: next_dr_sh = `BST_ID_VALUE;
            `BST_IR_EXTEST, `BST_IR_SAMPLEZ, `BST_IR_SAMPLE:
              next_dr_sh = {{(`BST_ID_W-`BST_BSR_W){1'b0}}, pins_s2};
            default: next_dr_sh = '0;
          endcase
        end
        SH_DR: begin
          case (ir)
            `BST_IR_IDCODE: next_dr_sh = {tdi, dr_sh[`BST_ID_W-1:1]};
            `BST_IR_EXTEST, `BST_IR_SAMPLEZ, `BST_IR_SAMPLE:
              next_dr_sh = {{(`BST_ID_W-`BST_BSR_W){1'b0}}, tdi,
                            dr_sh[`BST_BSR_W-1:1]};
            default: next_byp = tdi;
          endcase
        end
        UPD_DR: if (ir == `BST_IR_EXTEST) next_bsr_upd = dr_sh[`BST_BSR_W-1:0];
        default: ;
      endcase
    end
  end
  always_comb begin
    next_tdo = tdo;
    next_oe = oe;
    if (fall) begin
      next_oe = (state == SH_IR) || (state == SH_DR);
      if (state == SH_IR) next_tdo = ir_sh[0];
      else if (state == SH_DR) begin
        case (ir)
          `BST_IR_IDCODE, `BST_IR_EXTEST, `BST_IR_SAMPLEZ, `BST_IR_SAMPLE:
            next_tdo = dr_sh[0];
          default: next_tdo = byp;
        endcase
      end
    end
    next_own = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_SAMPLEZ);
    next_flt = (ir == `BST_IR_SAMPLEZ);
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= TLR;
      ir <= `BST_IR_IDCODE;
      ir_sh <= `BST_IR_IDCODE;
      dr_sh <= '0;
      bsr_upd <= '0;
      byp <= 1'b0;
      tdo <= 1'b0;
      oe <= 1'b0;
      own <= 1'b0;
      flt <= 1'b0;
    end else begin
      state <= next_state;
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      dr_sh <= next_dr_sh;
      bsr_upd <= next_bsr_upd;
      byp <= next_byp;
      tdo <= next_tdo;
      oe <= next_oe;
      own <= next_own;
      flt <= next_flt;
    end
  end
  assign tdo_o = tdo;
  assign tdo_oe_o = oe;
  assign pins_out_o = bsr_upd;
  assign test_own_o = own;
  assign outs_float_o = flt;
  assign state_o = state;

  // Five rising edges with mode select high must reach reset state
  logic [2:0] ones_cnt;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) ones_cnt <= 3'h0;
    else if (rise) ones_cnt <= !tms ? 3'h0 : (ones_cnt == 3'h5 ? ones_cnt : ones_cnt + 3'h1);
  end
  property p_five_ones;
    @(posedge core_clk_i) disable iff (sys_rst_i) (ones_cnt == 3'h5) |-> state == TLR;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("No reset after five ones");
  property p_hold;
    @(posedge core_clk_i) disable iff (sys_rst_i) !rise |=> $stable(state);
  endproperty
  a_hold: assert property (p_hold) else $error("State moved without edge");
  property p_tlr_exit;
    @(posedge core_clk_i) disable iff (sys_rst_i) (rise && state == TLR && !tms) |=> state == RTI;
  endproperty
  a_tlr_exit: assert property (p_tlr_exit) else $error("Bad exit from reset");
  property p_ir_shift;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (rise && state == SH_IR) |=> ir_sh[`BST_IR_W-1] == $past(tdi);
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("Instruction shift lost data");
  property p_tdo_fall;
    @(posedge core_clk_i) disable iff (sys_rst_i) !fall |=> $stable(tdo_o) && $stable(tdo_oe_o);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("Output moved off falling edge");
  property p_oe;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      fall |=> tdo_oe_o == ($past(state) == SH_IR || $past(state) == SH_DR);
  endproperty
  a_oe: assert property (p_oe) else $error("Output enable outside shift");
  property p_upd_ir;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (rise && state != UPD_IR && next_state != TLR) |=> $stable(ir);
  endproperty
  a_upd_ir: assert property (p_upd_ir) else $error("Instruction changed early");
  property p_cap_ir;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (rise && state == CAP_IR) |=> ir_sh == `BST_IR_IDCODE;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("Capture-IR did not load id");
  property p_own;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      ##1 test_own_o == ($past(ir) == `BST_IR_EXTEST || $past(ir) == `BST_IR_SAMPLEZ);
  endproperty
  a_own: assert property (p_own) else $error("Pin ownership wrong");
  c_shift_dr: cover property (@(posedge core_clk_i) state == SH_DR && tdo_oe_o);
  c_upd_ir: cover property (@(posedge core_clk_i) rise && state == UPD_IR);
  c_extest: cover property (@(posedge core_clk_i) test_own_o && !outs_float_o);
endmodule // bst_tap
`default_nettype wire

// ### bench/bst_ctl.sv
// Purpose: Test controller model driving the scan port pins
// Assumes: Core clock paces the test clock, eight cycles a period
// Notes: A released data out reads as the inverse of the last capture
`timescale 1ns/100ps
`default_nettype none
module bst_ctl (
  input wire logic core_clk_i, // Core clock
  input wire logic tdo_i, // Serial data from port
  input wire logic tdo_oe_i, // Port drive enable
  output var logic tck_o, // Test clock, left high between frames
  output var logic tms_o, // Mode select, pulled high
  output var logic tdi_o // Serial data, pulled high
);
  logic q_last = 1'b0;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  task automatic tick(input logic m, input logic d, output logic q, output logic oe);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge core_clk_i);
    // Capture at our own rising edge; output settled since the fall
    q = tdo_oe_i ? tdo_i : ~q_last;
    q_last = q;
    oe = tdo_oe_i;
    tck_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
endmodule // bst_ctl
`default_nettype wire

// ### bench/boundary_scan_test_port_bench.sv
// Purpose: Self-checking bench for the scan port
// Assumes: Reference model tracks state, instruction and shift path
// Notes: Lagging outputs are checked one test clock later
`timescale 1ns/100ps
`default_nettype none
`include "bst_map.svh"
module boundary_scan_test_port_bench;
  import bst_pkg::*;
  localparam logic [63:0] nx0 = 64'h1bddbba146644311;
  localparam logic [63:0] nx1 = 64'h2fefcc0287855920;
  logic core_clk, sys_rst, tck, tms, tdi, tdo, tdo_oe, own, flt;
  logic [7:0] pins_in, pins_out;
  logic [7:0] po = 8'h0;
  logic [31:0] sr = 32'h0;
  logic [2:0] ir = 3'h1;
  bst_state_t st;
  int num_errors = 0, compares = 0, s = 0, len = 3;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  bst_tap i_dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .pins_in_i(pins_in), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pins_out_o(pins_out),
    .test_own_o(own), .outs_float_o(flt), .state_o(st));
  bst_ctl i_ctl (.core_clk_i(core_clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string msg);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic step(input logic m, input logic d);
    logic q, oe, e_oe, e_tdo, e_own, e_flt;
    logic [7:0] p;
    e_oe = (s == 4 || s == 11);
    e_tdo = sr[0];
    e_own = (ir == 3'h0 || ir == 3'h2);
    e_flt = (ir == 3'h2);
    p = 8'($urandom);
    pins_in <= p;
    case (s)
      3: begin // Capture into the selected data path
        len = (ir == 3'h1) ? 32 : (ir == 3'h0 || ir == 3'h2 || ir == 3'h4) ? 8 : 1;
        sr = (ir == 3'h1) ? `BST_ID_VALUE : (len == 8) ? {24'h0, p} : 32'h0;
      end
      4, 11: sr = (sr >> 1) | (32'(d) << (len - 1));
      8: po = (ir == 3'h0) ? sr[7:0] : po;
      10: begin
        len = 3;
        sr = 32'h1;
      end
      15: ir = sr[2:0];
      default: ;
    endcase
    s = m ? int'(nx1[s*4 +: 4]) : int'(nx0[s*4 +: 4]);
    if (s == 0) ir = 3'h1;
    i_ctl.tick(m, d, q, oe);
    chk(32'(st), 32'(s), "controller state");
    chk(32'(oe), 32'(e_oe), "drive enable");
    if (e_oe) chk(32'(q), 32'(e_tdo), "serial out");
    chk(32'(own), 32'(e_own), "pins taken");
    chk(32'(flt), 32'(e_flt), "outputs floated");
    chk(32'(pins_out), 32'(po), "boundary drive");
    @(posedge core_clk);
  endtask
  task automatic walk(input logic [63:0] t, input logic [63:0] d, input int n);
    for (int i = 0; i < n; i++) step(t[i], d[i]);
  endtask
  initial begin
    void'($urandom(32'hc035));
    sys_rst = 1'b1;
    pins_in = 8'h0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int c = 0; c < 8; c++) begin
      walk(64'h186, 64'(c) << 5, 10);
      walk(64'h00000c0000000001, {$urandom, $urandom}, 45);
    end
    $display("instruction scans done");
    for (int i = 0; i < 300; i++) step(1'($urandom), 1'($urandom));
    $display("random walk done");
    walk(64'hf85f, {$urandom, $urandom}, 16);
    chk(32'(st), 32'(TLR), "five ones reset");
    $display("mid-shift reset done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    summarize();
  end
endmodule // boundary_scan_test_port_bench
`default_nettype wire
